/* afbp_host.sv */
// host controller driving the byte-wide memory port pins
`default_nettype none
module afbp_host
  import afbp_pkg::*;
#(
  parameter int PWRUP_CYCLES = PWRUP_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              req_valid,
  input  wire afbp_req_t         req,
  output logic                   req_ready,
  output afbp_rsp_t              rsp,
  output logic                   mem_sel_n,
  output logic                   mem_wstrobe_n,
  output logic                   mem_ogate_n,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [DATA_W-1:0]      mem_dq_o,
  output logic                   mem_dq_oe_n,
  input  wire logic [DATA_W-1:0] mem_dq_i
);
  // ==========================================================
  // pin input synchroniser
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q, dq_s3_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      dq_s3_q <= '0;
    end else if (clk_en) begin
      dq_s1_q <= mem_dq_i;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end
  wire dq_stable = (dq_s2_q == dq_s3_q);

  // ==========================================================
  // sequencer
  afbp_state_t       st_q, st_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [CNT_W-1:0]  cyc_q, cyc_d;
  logic              wr_q;
  wire cnt_done = (cnt_q == CNT_ZERO);
  wire cyc_done = (cyc_q == CNT_ZERO);
  wire take     = (st_q == AFBP_IDLE) && req_valid;
  wire [CNT_W-1:0] cyc_dec = cyc_done ? CNT_ZERO : CNT_W'(cyc_q - 1'b1);
  wire [CNT_W-1:0] cnt_dec = CNT_W'(cnt_q - 1'b1);

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_done ? CNT_ZERO : cnt_dec;
    cyc_d = cyc_dec;
    case (st_q)
      AFBP_PWRUP: if (cnt_done) st_d = AFBP_IDLE;
      AFBP_IDLE: begin
        if (req_valid) begin
          st_d  = AFBP_SEL;
          cnt_d = CNT_W'(SEL_CYC - STB_CYC - 1);
          cyc_d = CNT_W'(CYC_CYC - 1);
        end
      end
      AFBP_SEL: begin
        if (cnt_done) begin
          st_d  = wr_q ? AFBP_STB : AFBP_HOLD;
          cnt_d = CNT_W'(STB_CYC - 1);
        end
      end
      AFBP_STB: if (cnt_done) begin
        st_d  = AFBP_HOLD;
        cnt_d = CNT_W'(0);
      end
      // a write ends without waiting, the bus floats and never settles
      AFBP_HOLD: if (cnt_done && (dq_stable || wr_q)) begin
        st_d  = AFBP_PRE;
        cnt_d = CNT_W'(PRE_CYC - 1);
      end
      AFBP_PRE: if (cnt_done && cyc_done) st_d = AFBP_IDLE;
      default: st_d = AFBP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= AFBP_PWRUP;
      cnt_q <= CNT_W'(PWRUP_CYCLES);
      cyc_q <= CNT_ZERO;
    end else if (clk_en) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      cyc_q <= cyc_d;
    end
  end

  // ==========================================================
  // pin drive, all registered
  wire sel_d  = (st_d == AFBP_SEL) || (st_d == AFBP_STB) || (st_d == AFBP_HOLD);
  wire stb_d  = (st_d == AFBP_STB);
  // drive data FLOAT_CYC + 1 cycles (three cycles) after strobe falls
  wire dq_en_d = wr_q && (st_q == AFBP_STB) && (cnt_q <= CNT_W'(STB_CYC - 1 - FLOAT_CYC));
  // gate only enables reads on the bus
  wire og_d   = sel_d && !(take ? req.wr : wr_q);
  wire read_done = (st_q == AFBP_HOLD) && (st_d == AFBP_PRE);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q          <= 1'b0;
      mem_sel_n     <= 1'b1;
      mem_wstrobe_n <= 1'b1;
      mem_ogate_n   <= 1'b1;
      mem_addr      <= '0;
      mem_dq_o      <= '0;
      mem_dq_oe_n   <= 1'b1;
      req_ready     <= 1'b0;
      rsp           <= '0;
    end else if (clk_en) begin
      if (take) begin
        wr_q     <= req.wr;
        mem_addr <= req.addr;
        mem_dq_o <= req.wdata;
      end
      mem_sel_n     <= !sel_d;
      mem_wstrobe_n <= !stb_d;
      mem_ogate_n   <= !og_d;
      // write data held until one cycle after strobe rise
      mem_dq_oe_n   <= !(dq_en_d || (stb_d && mem_dq_oe_n == 1'b0));
      req_ready     <= (st_d == AFBP_IDLE);
      rsp.done      <= read_done;
      if (read_done && !wr_q) rsp.rdata <= dq_s3_q;
    end
  end
endmodule : afbp_host
`default_nettype wire

/* afbp_mem_model.sv */
// behavioural model of the byte-wide memory
`default_nettype none
module afbp_mem_model
  import afbp_pkg::*;
#(parameter int ACC_NS = 50) (
  input wire logic              sel_n,
  input wire logic              wstrobe_n,
  input wire logic              ogate_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq,
  output logic                  drv_en,
  output logic [DATA_W-1:0]     drv_data
);
  timeunit 1ns / 1ps;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [ADDR_W-1:0] a_q;
  logic              wr_q = 1'b0, rd, rd_late;
  assign rd = !sel_n && wstrobe_n && !ogate_n;
  assign #(ACC_NS) rd_late = rd;
  assign drv_en = rd && rd_late;
  assign drv_data = mem[a_q];
  // latch address, start write
  // sample just after the edge, the address settles in the same step
  always @(negedge sel_n) #1 {a_q, wr_q} = {addr, !wstrobe_n};
  always @(negedge wstrobe_n) wr_q = wr_q || !sel_n;
  always @(posedge wstrobe_n or posedge sel_n) if (wr_q) {mem[a_q], wr_q} = {dq, 1'b0};
endmodule : afbp_mem_model
`default_nettype wire

/* afbp_pkg.sv */
// package for the byte-wide nonvolatile memory port host controller
`default_nettype none
package afbp_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_PS = 8000;
  // timing figures in ns except the last two in us and ms, high supply then low supply
  localparam int SELECT_ACTIVE_MIN_NS     = 70;
  localparam int SELECT_ACTIVE_MIN_LV_NS  = 80;
  localparam int STROBE_PULSE_MIN_NS      = 40;
  localparam int STROBE_PULSE_MIN_LV_NS   = 50;
  localparam int PRECHARGE_MIN_NS         = 60;
  localparam int PRECHARGE_MIN_LV_NS      = 65;
  localparam int WRITE_CYCLE_MIN_NS       = 130;
  localparam int WRITE_CYCLE_MIN_LV_NS    = 145;
  localparam int STROBE_FALL_TO_FLOAT_NS  = 15;
  localparam int SELECT_RISE_TO_FLOAT_NS  = 15;
  localparam int LAST_WRITE_TO_POWERDOWN_US = 0;
  localparam int POWERUP_TO_FIRST_ACCESS_MS = 10;
  // least times rounded up to whole cycles
  localparam int SEL_CYC    = (SELECT_ACTIVE_MIN_LV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STB_CYC    = (STROBE_PULSE_MIN_LV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PRE_CYC    = (PRECHARGE_MIN_LV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FLOAT_CYC  = (STROBE_FALL_TO_FLOAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_CYC    = (WRITE_CYCLE_MIN_LV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PWRUP_CYC  = (POWERUP_TO_FIRST_ACCESS_MS * 1000000 + CLK_PERIOD_PS / 1000 - 1)
                              / (CLK_PERIOD_PS / 1000);
  localparam int CNT_W = 21;
  localparam logic [CNT_W-1:0] CNT_ZERO = 21'h000000;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } afbp_req_t;

  typedef struct packed {
    logic              done;
    logic [DATA_W-1:0] rdata;
  } afbp_rsp_t;

  typedef enum logic [2:0] {
    AFBP_PWRUP = 3'h0,
    AFBP_IDLE  = 3'h1,
    AFBP_SEL   = 3'h3,
    AFBP_STB   = 3'h2,
    AFBP_HOLD  = 3'h6,
    AFBP_PRE   = 3'h7
  } afbp_state_t;
endpackage : afbp_pkg
`default_nettype wire

/* afbp_properties.sv */
// pin timing checker for the host port
`default_nettype none
module afbp_properties
  import afbp_pkg::*;
#(parameter int PWRUP_CYCLES = PWRUP_CYC) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic mem_sel_n,
  input wire logic mem_wstrobe_n,
  input wire logic mem_ogate_n,
  input wire logic mem_dq_oe_n
);
  timeunit 1ns / 1ps;
  int lo_q, up_q;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) {lo_q, up_q} <= 64'h0;
    else {lo_q, up_q} <= {mem_sel_n ? 32'h0 : lo_q + 1, up_q + int'(up_q < PWRUP_CYCLES)};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_sel_low_min: assert property ($rose(mem_sel_n) |-> lo_q >= SEL_CYC)
    else $error("select short");
  a_sel_to_rise: assert property ($rose(mem_wstrobe_n) |-> !mem_sel_n && lo_q >= SEL_CYC)
    else $error("strobe early");
  a_strobe_min: assert property ($fell(mem_wstrobe_n) |=> !mem_wstrobe_n [*6])
    else $error("strobe short");
  a_precharge_min: assert property ($rose(mem_sel_n) |=> mem_sel_n [*8])
    else $error("precharge short");
  a_powerup_wait: assert property ($fell(mem_sel_n) |-> up_q >= PWRUP_CYCLES)
    else $error("early access");
  a_strobe_in_sel: assert property (!mem_wstrobe_n |-> !mem_sel_n)
    else $error("strobe outside select");
  a_gate_not_write: assert property (!mem_ogate_n |-> mem_wstrobe_n && mem_dq_oe_n)
    else $error("gate open in write");
  a_drive_after_float: assert property ($fell(mem_dq_oe_n) |->
    !mem_wstrobe_n && $past(mem_wstrobe_n, 2) == 1'b0)
    else $error("data driven too early");
endmodule : afbp_properties
bind afbp_host afbp_properties #(.PWRUP_CYCLES(PWRUP_CYCLES)) i_props (.core_clk, .rst_n,
  .mem_sel_n, .mem_wstrobe_n, .mem_ogate_n, .mem_dq_oe_n);
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the byte port host
`default_nettype none
module tb_top;
  import afbp_pkg::*;
  timeunit 1ns / 1ps;
  logic core_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_ready, mem_sel_n, mem_wstrobe_n;
  logic mem_ogate_n, mem_dq_oe_n, m_en;
  logic [ADDR_W-1:0] mem_addr, ad [10];
  logic [DATA_W-1:0] mem_dq_o, m_d, dq, flt = 8'h5A, last = 8'h00, rm [2**ADDR_W], eq [$];
  afbp_req_t req = 24'h000000;
  afbp_rsp_t rsp;
  int bad_count = 0, n_compared = 0, n;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) flt <= ~flt;
  assign #1 dq = !mem_dq_oe_n ? mem_dq_o : m_en ? m_d : flt;
  afbp_host #(.PWRUP_CYCLES(20)) i_dut (.core_clk, .rst_n, .clk_en(1'b1), .req_valid, .req,
    .req_ready, .rsp, .mem_sel_n, .mem_wstrobe_n, .mem_ogate_n, .mem_addr, .mem_dq_o,
    .mem_dq_oe_n, .mem_dq_i(dq));
  afbp_mem_model i_mem (.sel_n(mem_sel_n), .wstrobe_n(mem_wstrobe_n), .ogate_n(mem_ogate_n),
    .addr(mem_addr), .dq, .drv_en(m_en), .drv_data(m_d));
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    bad_count += int'(s !== e);
    if (s !== e) $display("CHECK FAILED %0t %h %h", $time, s, e);
  endtask : chk
  task close_out(input int x);
    bad_count += x;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    {req_valid, req} = {1'b1, w, a, d};
    for (n = 0; !req_ready && n < 300; n++) @(posedge core_clk) #1;
    if (n >= 300) close_out(1);
    if (w) rm[a] = d;
    else last = rm[a];
    eq.push_back(last);
    @(posedge core_clk) #1;
  endtask : access
  always @(posedge core_clk) if (rsp.done) chk(rsp.rdata, eq.pop_front());
  initial begin
    void'($urandom(32'h0FB9));
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 20; i++) begin
      if (i < 10) ad[i] = i == 0 ? 15'h0000 : i == 1 ? 15'h7FFF : 15'($urandom);
      access(i < 10, ad[i < 10 ? i : 19 - i], 8'($urandom));
    end
    req_valid = 1'b0;
    for (n = 0; eq.size() > 0 && n < 300; n++) @(posedge core_clk);
    if (n >= 300) close_out(1);
    $display("write and read back test done");
    close_out(0);
  end
endmodule : tb_top
`default_nettype wire
